//--- tb_usbt.sv
// testbench: registers, async frames, abort and slave shifting
`timescale 1ns/100ps
`include "usbt_map.svh"
module tb;
    logic        clk_i, resetn_i, hsel_i, hwrite_i, sleep_i, txck_in_i;
    logic        hready, hresp_o, txck_out_o, txck_oe_o, dt_out_o, dt_oe_o;
    logic        txirq_o, wake_o, nine;
    logic [1:0]  htrans_i;
    logic [31:0] haddr_i, hwdata_i, hrdata_o;
    logic [15:0] bitc;
    logic [8:0]  rx_data;
    logic [7:0]  rx_cnt, rx_ferr;
    int          fails = 0;
    int          checks = 0;
    int          cyc = 0;

    usbt_transmitter dut (.clk_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
        .hwrite_i, .hsize_i(3'b010), .hwdata_i, .hready_i(hready),
        .hrdata_o, .hreadyout_o(hready), .hresp_o, .sleep_i, .txck_in_i,
        .txck_out_o, .txck_oe_o, .dt_in_i(1'b1), .dt_out_o, .dt_oe_o,
        .txirq_o, .wake_o);
    usbt_line_rx rx (.clk_i, .line_i(txck_oe_o ? txck_out_o : 1'b1),
        .bit_clks_i(bitc), .nine_i(nine), .data_o(rx_data), .count_o(rx_cnt),
        .ferr_o(rx_ferr));

    // 125 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // cut a hang short
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            fails = fails + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input string what, input logic [31:0] exp, got);
        checks = checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one single-word transfer; address held until hready, then data phase
    task automatic bus(input logic wr, input logic [7:0] idx,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        hsel_i <= 1'b1;
        htrans_i <= 2'b10;
        hwrite_i <= wr;
        haddr_i <= {22'h0, idx, 2'b00};
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans_i <= 2'b00;
        hwdata_i <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata_o;
    endtask : bus
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, d);
    endtask : wr
    task automatic rd(input string w, input logic [7:0] idx,
                      input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0000_0000, d);
        chk(w, exp, d);
    endtask : rd
    task automatic wait_rx(input logic [7:0] n);
        while (rx_cnt !== n) @(posedge clk_i);
    endtask : wait_rx

    task automatic t_reset();
        rd("tsc", `USBT_IDX_TRANSMIT_SC, 32'h0000_0002);
        rd("divisor", `USBT_IDX_BAUD_DIV, 32'h0000_0000);
        rd("unmapped", 8'h40, 32'h0000_0000);
        chk("hresp", 32'h0, hresp_o);
    endtask : t_reset
    // two queued words at high speed, divisor 0
    task automatic t_async();
        wr(`USBT_IDX_PERIPH_EN, 32'h0000_0010);
        wr(`USBT_IDX_RECV_SC, 32'h0000_0080);
        wr(`USBT_IDX_TRANSMIT_SC, 32'h0000_0024);
        rd("flag", `USBT_IDX_PERIPH_FLAG, 32'h0000_0010);
        chk("idle", 32'h3, {txck_oe_o, txck_out_o});
        wr(`USBT_IDX_HOLDING, 32'h0000_0055);
        wr(`USBT_IDX_HOLDING, 32'h0000_00A3);
        rd("flag", `USBT_IDX_PERIPH_FLAG, 32'h0000_0000);
        chk("irq", 32'h0, txirq_o);
        wait_rx(8'd1);
        chk("rx1", 32'h55, rx_data);
        repeat (16) @(posedge clk_i);
        rd("flag", `USBT_IDX_PERIPH_FLAG, 32'h0000_0010);
        chk("irq", 32'h1, txirq_o);
        wait_rx(8'd2);
        chk("rx2", 32'h0A3, rx_data);
        repeat (32) @(posedge clk_i);
        rd("tsc", `USBT_IDX_TRANSMIT_SC, 32'h0000_0026);
    endtask : t_async
    // nine bits, low speed, divisor 1
    task automatic t_nine();
        wr(`USBT_IDX_BAUD_DIV, 32'h0000_0001);
        bitc = 16'd128;
        nine = 1'b1;
        wr(`USBT_IDX_TRANSMIT_SC, 32'h0000_0061);
        wr(`USBT_IDX_HOLDING, 32'h0000_003C);
        wait_rx(8'd3);
        chk("rx9", 32'h13C, rx_data);
        chk("ferr", 32'h0, rx_ferr);
    endtask : t_nine
    task automatic t_abort();
        wr(`USBT_IDX_BAUD_DIV, 32'h0000_0000);
        wr(`USBT_IDX_TRANSMIT_SC, 32'h0000_0024);
        wr(`USBT_IDX_HOLDING, 32'h0000_000F);
        repeat (60) @(posedge clk_i);
        wr(`USBT_IDX_TRANSMIT_SC, 32'h0000_0004);
        repeat (2) @(posedge clk_i);
        chk("oe", 32'h0, txck_oe_o);
        rd("tsc", `USBT_IDX_TRANSMIT_SC, 32'h0000_0006);
    endtask : t_abort
    // sync master, high speed ignored, divisor 1: eight clocks a bit
    task automatic t_master();
        wr(`USBT_IDX_BAUD_DIV, 32'h0000_0001);
        wr(`USBT_IDX_TRANSMIT_SC, 32'h0000_00B4);
        wr(`USBT_IDX_HOLDING, 32'h0000_0096);
        while (dt_oe_o !== 1'b1) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
            repeat (4) @(posedge clk_i);
            chk("mdt", {31'h1, 1'(8'h96 >> i)},
                {dt_oe_o, dt_out_o});
            repeat (4) @(posedge clk_i);
        end
    endtask : t_master
    // slave shifting while asleep, two words queued, remote clock
    task automatic t_slave();
        wr(`USBT_IDX_TRANSMIT_SC, 32'h0000_0030);
        sleep_i <= 1'b1;
        wr(`USBT_IDX_HOLDING, 32'h0000_00C6);
        wr(`USBT_IDX_HOLDING, 32'h0000_005A);
        rd("flag", `USBT_IDX_PERIPH_FLAG, 32'h0000_0000);
        for (int i = 0; i < 17; i++) begin
            @(posedge clk_i);
            txck_in_i <= 1'b0;
            repeat (4) @(posedge clk_i);
            txck_in_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            if (i < 16)
                chk("dt", {31'h1, 1'(16'h5AC6 >> i)},
                    {dt_oe_o, dt_out_o});
        end
        chk("dt_oe", 32'h0, dt_oe_o);
        chk("wake", 32'h1, wake_o);
    endtask : t_slave

    initial begin
        resetn_i = 1'b0;
        hsel_i = 1'b0;
        htrans_i = 2'b00;
        hwrite_i = 1'b0;
        haddr_i = 32'h0000_0000;
        hwdata_i = 32'h0000_0000;
        sleep_i = 1'b0;
        txck_in_i = 1'b1;
        bitc = 16'd16;
        nine = 1'b0;
        repeat (20) @(posedge clk_i);
        resetn_i <= 1'b1;
        t_reset();
        t_async();
        t_nine();
        t_abort();
        t_master();
        t_slave();
        end_of_test();
    end
endmodule : tb

//--- usbt_baud_gen.sv
// baud rate generator: divisor timer and per-mode bit prescaler
`timescale 1ns/100ps
`include "usbt_map.svh"
module usbt_baud_gen #(
    parameter int DIV_W = 8,
    parameter int PRE_W = 7
) (
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    input  wire logic [DIV_W-1:0] divisor_i,
    input  wire logic             clear_i,
    input  wire logic             sync_i,
    input  wire logic             high_speed_i,
    input  wire logic             run_i,
    output logic                  bit_tick_o,
    output logic                  low_half_o
);
    logic [DIV_W-1:0] cnt;
    logic [PRE_W-1:0] pre;
    logic [PRE_W-1:0] presc;
    logic             gen_tick;

    // bit prescale per mode, high speed ignored in sync mode
    function automatic logic [PRE_W-1:0] prescale(input logic s,
                                                  input logic h);
        if (s)
            prescale = PRE_W'(`USBT_PRE_SYNC); // RQ2 RQ27
        else if (h)
            prescale = PRE_W'(`USBT_PRE_ASYNC_HIGH); // RQ1 RQ7
        else
            prescale = PRE_W'(`USBT_PRE_ASYNC_LOW); // RQ1 RQ7
    endfunction : prescale

    assign presc      = prescale(sync_i, high_speed_i);
    assign gen_tick   = run_i && (cnt == divisor_i); // RQ3
    assign bit_tick_o = gen_tick && (pre >= presc - PRE_W'(1));
    assign low_half_o = pre < (presc >> 1);

    // free-running divisor timer, cleared by a divisor write
    always_ff @(posedge clk_i) begin
        if (!resetn_i || clear_i) begin
            cnt <= '0; // RQ26
        end else if (run_i) begin
            cnt <= gen_tick ? '0 : cnt + DIV_W'(1); // RQ25
        end
    end

    // prescaler from generator rate down to bit rate
    always_ff @(posedge clk_i) begin
        if (!resetn_i || clear_i) begin
            pre <= '0;
        end else if (gen_tick) begin
            pre <= bit_tick_o ? '0 : pre + PRE_W'(1); // RQ7
        end
    end

    AST_DIV_CLEAR: assert property (@(posedge clk_i) // RQ26
        disable iff (!resetn_i) clear_i |=> (cnt == '0) && (pre == '0))
        else $error("baud timer not cleared by divisor write");
    AST_SYNC_RATE: assert property (@(posedge clk_i) // RQ2
        disable iff (!resetn_i)
        (sync_i && gen_tick && pre == PRE_W'(3)) |-> bit_tick_o)
        else $error("sync bit tick not every fourth generator tick");
endmodule : usbt_baud_gen

//--- usbt_line_rx.sv
// partner model: remote receiver decoding frames on the transmit line
`timescale 1ns/100ps
module usbt_line_rx (
    input  wire logic        clk_i,
    input  wire logic        line_i,
    input  wire logic [15:0] bit_clks_i,
    input  wire logic        nine_i,
    output logic      [8:0]  data_o,
    output logic      [7:0]  count_o,
    output logic      [7:0]  ferr_o
);
    // find the start edge, sample each bit mid-period, lsb arrives first
    initial begin
        count_o = 8'h00;
        ferr_o = 8'h00;
        data_o = 9'h000;
        forever begin
            @(negedge line_i);
            repeat (bit_clks_i / 2) @(posedge clk_i);
            for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
                repeat (bit_clks_i) @(posedge clk_i);
                data_o = {line_i, data_o[8:1]};
            end
            if (!nine_i)
                data_o = data_o >> 1;
            repeat (bit_clks_i) @(posedge clk_i);
            if (line_i !== 1'b1)
                ferr_o = ferr_o + 8'h01;
            count_o = count_o + 8'h01;
        end
    end
endmodule : usbt_line_rx

//--- usbt_map.svh
// register map, field positions, reset values and rates of the transmitter
// Operation
// RQ1: async rate is clock over 64(divisor+1), or 16(divisor+1) at high speed
// RQ2: sync rate is clock over 4(divisor+1); no high-speed variant
// RQ3: the divisor is 8 bits, 0 to 255, used directly in every rate
// RQ4: async frame is start, eight or nine data bits, stop; no parity
// RQ5: data leaves least significant bit first
// RQ6: transmitter and receiver share one data format and one baud rate
// RQ7: async generator runs at 16x or 64x the bit rate
// RQ8: sync mode bit clear selects async; async stops during sleep
// RQ9: shift register reloads only after the previous stop bit has gone
// RQ10: holding to shift move takes one cycle, then buffer-empty flag sets
// RQ11: buffer-empty flag ignores software clears; a holding write clears it
// RQ12: interrupt request only when flag and transmit interrupt enable are set
// RQ13: shift-empty status is read-only, reads 1 when empty, no interrupt
// RQ14: setting transmit enable sets the buffer-empty flag
// RQ15: shifting starts only with data held and a shift clock issued
// RQ16: data loaded before enabling still goes out once enabled
// RQ17: a write with the shift register empty passes straight through
// RQ18: clearing transmit enable aborts the frame and floats the pin
// RQ19: software writes the ninth bit before the holding register
// RQ20: slave mode takes the shift clock from the clock pin, even asleep
// RQ21: asleep with two words queued, flag sets when the second moves over
// RQ22: the flag with its enable set wakes the chip from sleep
// RQ23: software sets both pins as inputs, then sync and port enable
// RQ24: software clears receive enables, enables, then loads the data
// RQ25: the divisor sets the period of a free-running 8-bit timer
// RQ26: a divisor write clears the baud timer at once
// RQ27: high-speed select has no effect in sync mode
// RQ28: async idle line holds the mark level between frames
// RQ29: slave shifts one bit per external clock, drives data only then
`ifndef USBT_MAP_SVH
`define USBT_MAP_SVH
// register indexes, byte address is four times the index
`define USBT_IDX_PERIPH_FLAG  8'h0C
`define USBT_IDX_RECV_SC      8'h18
`define USBT_IDX_HOLDING      8'h19
`define USBT_IDX_PERIPH_EN    8'h8C
`define USBT_IDX_TRANSMIT_SC  8'h98
`define USBT_IDX_BAUD_DIV     8'h99
// transmit status/control fields
`define USBT_TSC_CLK_SRC      7
`define USBT_TSC_NINE         6
`define USBT_TSC_TRANSMIT_ENABLE_BIT         5
`define USBT_TSC_SYNC         4
`define USBT_TSC_HIGH_SPEED   2
`define USBT_TSC_SHIFT_EMPTY  1
`define USBT_TSC_NINTH        0
// receive status/control and flag/enable fields
`define USBT_RSC_PORT_EN      7
`define USBT_FLAG_BUF_EMPTY   4
`define USBT_EN_TX_IRQ        4
// reset values
`define USBT_RST_TSC          8'h02
`define USBT_RST_RSC          8'h00
`define USBT_RST_BAUD         8'h00
`define USBT_RST_EN           8'h00
// generator prescales per mode
`define USBT_PRE_ASYNC_LOW    7'h40
`define USBT_PRE_ASYNC_HIGH   7'h10
`define USBT_PRE_SYNC         7'h04
// bits per frame without the ninth bit
`define USBT_BITS_ASYNC       4'hA
`define USBT_BITS_SYNC        4'h8
`endif

//--- usbt_pkg.sv
// shared types of the transmitter
package usbt_pkg;
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_WAIT  = 3'b010,
        TX_SHIFT = 3'b100
    } usbt_tx_state_e;
    typedef enum logic [2:0] {
        MODE_ASYNC  = 3'b001,
        MODE_MASTER = 3'b010,
        MODE_SLAVE  = 3'b100
    } usbt_mode_e;
endpackage : usbt_pkg

//--- usbt_transmitter.sv
// serial transmitter with AHB-Lite register slave and shared baud generator
`timescale 1ns/100ps
`include "usbt_map.svh"
module usbt_transmitter #(
    parameter int DIV_W = 8
) (
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic      [31:0] hrdata_o,
    output logic             hreadyout_o,
    output logic             hresp_o,
    input  wire logic        sleep_i,
    input  wire logic        txck_in_i,
    output logic             txck_out_o,
    output logic             txck_oe_o,
    input  wire logic        dt_in_i,
    output logic             dt_out_o,
    output logic             dt_oe_o,
    output logic             txirq_o,
    output logic             wake_o
);
    ////////////////////////////////////////////////////////////////////////
    // registers and state
    logic                  ap_valid;
    logic                  ap_write;
    logic [7:0]            ap_idx;
    logic                  tsc_clk_src;
    logic                  tsc_nine;
    logic                  tsc_transmit_enable_bit;
    logic                  tsc_sync;
    logic                  tsc_hs;
    logic                  tsc_ninth;
    logic [7:0]            recv_sc;
    logic [DIV_W-1:0]      baud_div;
    logic [7:0]            periph_en;
    logic [7:0]            hold_data;
    logic                  hold_full;
    logic                  buf_empty_flag;
    logic [10:0]           shreg;
    logic [3:0]            bit_cnt;
    logic                  line;
    logic                  ck_q;
    usbt_pkg::usbt_tx_state_e state;
    usbt_pkg::usbt_mode_e  mode;
    logic                  wr_hold;
    logic                  wr_tsc;
    logic                  wr_baud;
    logic                  transmit_enable_bit_rise;
    logic                  bit_tick;
    logic                  low_half;
    logic                  ck_fall;
    logic                  shift_evt;
    logic                  transfer;
    logic                  port_on;
    logic [10:0]           frame;
    logic [3:0]            frame_len;
    logic [31:0]           next_rdata;

    // frame image, first bit out in bit 0
    function automatic logic [10:0] build_frame(input logic [7:0] d,
                                                input logic n9,
                                                input logic b9,
                                                input logic s);
        logic top;
        top = n9 ? b9 : 1'b1; // RQ19
        if (s)
            build_frame = {2'b11, top, d};
        else
            build_frame = {1'b1, top, d, 1'b0}; // RQ4 RQ5
    endfunction : build_frame

    // bits in a frame for the selected format
    function automatic logic [3:0] build_len(input logic n9,
                                             input logic s);
        build_len = (s ? `USBT_BITS_SYNC : `USBT_BITS_ASYNC)
                    + {3'b000, n9}; // RQ4
    endfunction : build_len

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    assign wr_hold   = ap_valid && ap_write && ap_idx == `USBT_IDX_HOLDING;
    assign wr_tsc    = ap_valid && ap_write && ap_idx == `USBT_IDX_TRANSMIT_SC;
    assign wr_baud   = ap_valid && ap_write && ap_idx == `USBT_IDX_BAUD_DIV;
    assign transmit_enable_bit_rise = wr_tsc && hwdata_i[`USBT_TSC_TRANSMIT_ENABLE_BIT] && !tsc_transmit_enable_bit;

    // address phase capture, zero wait states, always OKAY
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ap_valid    <= 1'b0;
            ap_write    <= 1'b0;
            ap_idx      <= 8'h00;
            hrdata_o    <= 32'h0000_0000;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            ap_valid    <= hsel_i && htrans_i[1] && hready_i;
            ap_write    <= hwrite_i;
            ap_idx      <= haddr_i[9:2];
            hrdata_o    <= next_rdata;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end
    end

    // read value chosen at the address phase; unmapped reads as zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hsel_i && htrans_i[1] && !hwrite_i && haddr_i[31:10] == '0) begin
            case (haddr_i[9:2])
                `USBT_IDX_TRANSMIT_SC: next_rdata[7:0] = {tsc_clk_src,
                    tsc_nine, tsc_transmit_enable_bit, tsc_sync, 1'b0, tsc_hs,
                    state == usbt_pkg::TX_IDLE, tsc_ninth}; // RQ13
                `USBT_IDX_RECV_SC:     next_rdata[7:0] = recv_sc;
                `USBT_IDX_BAUD_DIV:    next_rdata[7:0] = 8'(baud_div);
                `USBT_IDX_HOLDING:     next_rdata[7:0] = hold_data;
                `USBT_IDX_PERIPH_EN:   next_rdata[7:0] = periph_en;
                `USBT_IDX_PERIPH_FLAG:
                    next_rdata[`USBT_FLAG_BUF_EMPTY] = buf_empty_flag;
                default:               next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // control registers; shift-empty is not stored, it is the state
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            {tsc_clk_src, tsc_nine, tsc_transmit_enable_bit, tsc_sync} <=
                4'(`USBT_RST_TSC >> 4);
            tsc_hs    <= 1'(`USBT_RST_TSC >> `USBT_TSC_HIGH_SPEED);
            tsc_ninth <= 1'(`USBT_RST_TSC >> `USBT_TSC_NINTH);
            recv_sc   <= `USBT_RST_RSC;
            baud_div  <= DIV_W'(`USBT_RST_BAUD);
            periph_en <= `USBT_RST_EN;
        end else if (ap_valid && ap_write) begin
            case (ap_idx)
                `USBT_IDX_TRANSMIT_SC: begin
                    tsc_clk_src <= hwdata_i[`USBT_TSC_CLK_SRC];
                    tsc_nine    <= hwdata_i[`USBT_TSC_NINE];
                    tsc_transmit_enable_bit    <= hwdata_i[`USBT_TSC_TRANSMIT_ENABLE_BIT];
                    tsc_sync    <= hwdata_i[`USBT_TSC_SYNC]; // RQ8
                    tsc_hs      <= hwdata_i[`USBT_TSC_HIGH_SPEED];
                    tsc_ninth   <= hwdata_i[`USBT_TSC_NINTH];
                end
                `USBT_IDX_RECV_SC:   recv_sc   <= hwdata_i[7:0];
                `USBT_IDX_BAUD_DIV:  baud_div  <= hwdata_i[DIV_W-1:0]; // RQ3
                `USBT_IDX_PERIPH_EN: periph_en <= hwdata_i[7:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // baud generator shared by both directions

    // one generator and one format setting serve the whole port
    usbt_baud_gen #(
        .DIV_W (DIV_W),
        .PRE_W (7)
    ) u_baud (
        .clk_i        (clk_i),
        .resetn_i     (resetn_i),
        .divisor_i    (baud_div),
        .clear_i      (wr_baud),
        .sync_i       (tsc_sync),
        .high_speed_i (tsc_hs),
        .run_i        (!sleep_i),
        .bit_tick_o   (bit_tick),
        .low_half_o   (low_half)
    ); // RQ6 RQ8 RQ25 RQ26

    // mode decode and shift event source
    always_comb begin
        if (!tsc_sync)
            mode = usbt_pkg::MODE_ASYNC;
        else if (tsc_clk_src)
            mode = usbt_pkg::MODE_MASTER;
        else
            mode = usbt_pkg::MODE_SLAVE; // RQ20
    end

    assign ck_fall   = ck_q && !txck_in_i;
    assign shift_evt = (mode == usbt_pkg::MODE_SLAVE) ? ck_fall
                                                     : bit_tick; // RQ29
    assign port_on   = recv_sc[`USBT_RSC_PORT_EN] && tsc_transmit_enable_bit;
    assign frame     = build_frame(hold_data, tsc_nine, tsc_ninth, tsc_sync);
    assign frame_len = build_len(tsc_nine, tsc_sync);

    // external clock edge detector for slave mode
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ck_q <= 1'b1;
        end else begin
            ck_q <= txck_in_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // holding register and buffer-empty flag

    // move only when idle or right as the last bit period ends
    assign transfer = tsc_transmit_enable_bit && hold_full &&
        (state == usbt_pkg::TX_IDLE || (state == usbt_pkg::TX_SHIFT &&
         shift_evt && bit_cnt == 4'h0)); // RQ9 RQ16 RQ17

    // holding register; kept over a disable so a preload still goes out
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            hold_data <= 8'h00;
            hold_full <= 1'b0;
        end else if (wr_hold) begin
            hold_data <= hwdata_i[7:0];
            hold_full <= 1'b1;
        end else if (transfer) begin
            hold_full <= 1'b0; // RQ10
        end
    end

    // flag set by a move or by enabling, cleared only by a holding write
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            buf_empty_flag <= 1'b0;
        end else if (wr_hold) begin
            buf_empty_flag <= 1'b0; // RQ11
        end else if (transfer || transmit_enable_bit_rise) begin
            buf_empty_flag <= 1'b1; // RQ10 RQ14 RQ21
        end
    end

    // interrupt request and wake-up, both registered
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            txirq_o <= 1'b0;
            wake_o  <= 1'b0;
        end else begin
            txirq_o <= buf_empty_flag && periph_en[`USBT_EN_TX_IRQ]; // RQ12
            wake_o  <= sleep_i && buf_empty_flag &&
                       periph_en[`USBT_EN_TX_IRQ]; // RQ22
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shift register sequencer

    // load at once, the first bit waits for a shift event, then one bit per event
    always_ff @(posedge clk_i) begin
        if (!resetn_i || !tsc_transmit_enable_bit) begin
            state   <= usbt_pkg::TX_IDLE; // RQ18
            shreg   <= '1;
            bit_cnt <= 4'h0;
            line    <= 1'b1; // RQ28
        end else begin
            case (state)
                usbt_pkg::TX_IDLE: begin
                    if (hold_full) begin
                        shreg   <= frame; // RQ17
                        bit_cnt <= frame_len;
                        state   <= usbt_pkg::TX_WAIT;
                    end
                end
                usbt_pkg::TX_WAIT: begin
                    if (shift_evt) begin
                        line    <= shreg[0]; // RQ15 RQ5
                        shreg   <= {1'b1, shreg[10:1]};
                        bit_cnt <= bit_cnt - 4'h1;
                        state   <= usbt_pkg::TX_SHIFT;
                    end
                end
                usbt_pkg::TX_SHIFT: begin
                    if (shift_evt) begin
                        if (bit_cnt != 4'h0) begin
                            line    <= shreg[0]; // RQ5 RQ29
                            shreg   <= {1'b1, shreg[10:1]};
                            bit_cnt <= bit_cnt - 4'h1;
                        end else if (hold_full) begin
                            line    <= frame[0]; // RQ9
                            shreg   <= {1'b1, frame[10:1]};
                            bit_cnt <= frame_len - 4'h1;
                        end else begin
                            state   <= usbt_pkg::TX_IDLE;
                        end
                    end
                end
                default: state <= usbt_pkg::TX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers

    // async drives the line on the clock pin; sync drives data while busy
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            txck_out_o <= 1'b1;
            txck_oe_o  <= 1'b0;
            dt_out_o   <= 1'b1;
            dt_oe_o    <= 1'b0;
        end else begin
            case (mode)
                usbt_pkg::MODE_ASYNC: begin
                    txck_out_o <= line; // RQ28
                    txck_oe_o  <= port_on; // RQ18
                    dt_out_o   <= 1'b1;
                    dt_oe_o    <= 1'b0;
                end
                usbt_pkg::MODE_MASTER: begin
                    txck_out_o <= !(state == usbt_pkg::TX_SHIFT && low_half);
                    txck_oe_o  <= port_on;
                    dt_out_o   <= line;
                    dt_oe_o    <= port_on && state == usbt_pkg::TX_SHIFT;
                end
                default: begin
                    txck_out_o <= 1'b1;
                    txck_oe_o  <= 1'b0; // RQ20
                    dt_out_o   <= line;
                    dt_oe_o    <= port_on &&
                                  state == usbt_pkg::TX_SHIFT; // RQ29
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_FLAG_ON_ENABLE: assert property (transmit_enable_bit_rise |=> buf_empty_flag) // RQ14
        else $error("enable did not set buffer-empty flag");
    AST_WRITE_CLEARS: assert property (wr_hold |=> !buf_empty_flag) // RQ11
        else $error("holding write did not clear flag");
    AST_MOVE_SETS: assert property ((transfer && !wr_hold) |=> // RQ10
        buf_empty_flag && !hold_full && state != usbt_pkg::TX_IDLE)
        else $error("holding move did not complete in one cycle");
    AST_NO_EARLY_LOAD: assert property ((state == usbt_pkg::TX_SHIFT && // RQ9
        bit_cnt != 4'h0) |-> !transfer)
        else $error("shift register reloaded before stop bit");
    AST_WAIT_FOR_CLOCK: assert property ((state == usbt_pkg::TX_WAIT && // RQ15
        !shift_evt && tsc_transmit_enable_bit) |=> state == usbt_pkg::TX_WAIT)
        else $error("shifting began without a shift clock");
    AST_START_BIT: assert property ((state == usbt_pkg::TX_WAIT && // RQ4
        shift_evt && tsc_transmit_enable_bit && !tsc_sync) |=> !line ##1 !txck_out_o)
        else $error("async frame did not open with a start bit");
    // the sequencer sees the cleared enable one edge after the write lands
    AST_ABORT: assert property ($fell(tsc_transmit_enable_bit) |=> // RQ18
        state == usbt_pkg::TX_IDLE ##1 !txck_oe_o && !dt_oe_o)
        else $error("disable did not abort and float the pins");
    AST_IRQ_GATE: assert property ((buf_empty_flag && // RQ12
        !periph_en[`USBT_EN_TX_IRQ]) |=> !txirq_o)
        else $error("interrupt raised while disabled");
    AST_SLEEP_HALT: assert property ((sleep_i && !tsc_sync) |-> // RQ8
        !shift_evt)
        else $error("async shifting ran during sleep");
    AST_IDLE_MARK: assert property ((!tsc_sync && // RQ28
        state == usbt_pkg::TX_IDLE) [*2] |-> txck_out_o)
        else $error("idle async line not at mark level");
    AST_SLAVE_DRIVE: assert property ( // RQ29
        (mode == usbt_pkg::MODE_SLAVE && state != usbt_pkg::TX_SHIFT) |=>
        !dt_oe_o)
        else $error("slave drove data outside a word");
endmodule : usbt_transmitter
